//--- design/refclk_sel_pkg.sv
// package: register map, field layout and constants of the port reference clock selector
`default_nettype none
package refclk_sel_pkg;
  localparam int unsigned NUM_PORTS = 3;
  localparam logic [7:0]  MODE_REG_ADDR   = 8'h00; // port_clock_mode_reg
  localparam logic [7:0]  LINK_STS_ADDR   = 8'h04; // link_status_reg slot clock bits
  localparam logic [7:0]  CFG_REG_ADDR    = 8'h08; // merge and port disable
  localparam logic [7:0]  STATUS_REG_ADDR = 8'h0C; // read only state
  localparam int unsigned MERGE_BIT       = 0;
  localparam int unsigned DISABLE_LSB     = 4;
  localparam int unsigned FSEL_BIT        = 0;
  localparam int unsigned DETECT_LSB      = 4;
  localparam int unsigned ILLEGAL_BIT     = 8;
  localparam logic [2:0]  MODE_RESET      = 3'h0;
  localparam logic        MODE_GLOBAL     = 1'b0;
  localparam logic        MODE_LOCAL      = 1'b1;
  localparam int unsigned GLOBAL_REF_CLOCK_MHZ_LO     = 100;
  localparam int unsigned GLOBAL_REF_CLOCK_MHZ_HI     = 125;
  localparam int unsigned CORE_MHZ        = 250;
  localparam int unsigned PCS_MHZ         = 250;
  localparam int unsigned PMA_MHZ         = 5000;
  localparam int unsigned SYS_MHZ         = 20;
  localparam int unsigned DETECT_NS       = 400;
  localparam int unsigned DETECT_CYC      = (DETECT_NS * SYS_MHZ + 999) / 1000;
  localparam logic [31:0] PSLVERR_NONE    = 32'h0000_0000;
endpackage
`default_nettype wire

//--- design/port_clk_ctrl.sv
// one port's mode change sequencer: detect hold, serdes reinit and retrain pulses
`default_nettype none
module port_clk_ctrl #(
  parameter int unsigned HOLD_CYC = refclk_sel_pkg::DETECT_CYC
) (
  input  wire logic sys_clk_i,
  input  wire logic rst_n_i,
  input  wire logic ce_i,
  input  wire logic change_i,
  input  wire logic clk_src_changed_i,
  input  wire logic disabled_i,
  output logic      detect_o,
  output logic      reinit_o,
  output logic      retrain_o
);
  typedef enum logic [1:0] {IDLE, HOLD, DONE} st_t;
  typedef struct packed {
    st_t        st;
    logic [7:0] cnt;
    logic       detect;
    logic       reinit;
    logic       retrain;
    logic       pend_reinit;
  } state_t;
  state_t r, next_r;

  always_comb begin
    next_r = r;
    next_r.reinit  = 1'b0;
    next_r.retrain = 1'b0;
    case (r.st)
      IDLE: begin
        if (change_i) begin
          next_r.st          = HOLD;
          next_r.detect      = 1'b1;
          next_r.cnt         = 8'(HOLD_CYC);
          next_r.pend_reinit = clk_src_changed_i;
        end
      end
      HOLD: begin
        // a further change restarts the hold so the new clock settles too
        if (change_i) begin
          next_r.cnt         = 8'(HOLD_CYC);
          next_r.pend_reinit = r.pend_reinit | clk_src_changed_i;
        end else if (r.cnt <= 8'h01) begin
          next_r.st = DONE;
        end else begin
          next_r.cnt = r.cnt - 8'h01;
        end
      end
      DONE: begin
        next_r.st      = IDLE;
        next_r.detect  = 1'b0;
        next_r.reinit  = r.pend_reinit;
        next_r.retrain = !disabled_i;
        next_r.pend_reinit = 1'b0;
      end
      default: next_r.st = IDLE;
    endcase
  end

  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      r <= '{st: IDLE, cnt: 8'h00, detect: 1'b0, reinit: 1'b0, retrain: 1'b0,
             pend_reinit: 1'b0};
    end else if (ce_i) begin
      r <= next_r;
    end
  end

  assign detect_o  = r.detect;
  assign reinit_o  = r.reinit;
  assign retrain_o = r.retrain;

  a_detect_hold: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    (ce_i && r.st == IDLE && change_i) |=> detect_o)
    else $error("mode change did not enter detect");
  a_retrain_gate: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    retrain_o |-> $past(!disabled_i))
    else $error("retrain issued for disabled port");
endmodule
`default_nettype wire

//--- design/port_refclk_mode_select.sv
// top: per-port reference clock selection, strap load and apb registers
// Operation
// - port uses global or own clock per mode
// - each port holds independent mode bit
// - boot strap loads all ports global mode
// - strap code sets initial slot clock bits
// - slot clock bit drives partner advertisement
// - merged x8 port uses even port clock
// - frequency select picks 100 or 125 MHz
// - core clock derived at 250 MHz
// - quad pll gives 250 MHz pcs clock
// - mode change: detect, reinit if clock source changed, retrain unless disabled
//
// The placing of the registers and the APB register port were decided locally.
`default_nettype none
module port_refclk_mode_select #(
  parameter int unsigned NPORT = refclk_sel_pkg::NUM_PORTS
) (
  input  wire logic              sys_clk_i,
  input  wire logic              rst_n_i,
  input  wire logic              ce_i,
  input  wire logic [2:0]        boot_clock_strap_i,
  input  wire logic              boot_load_i,
  input  wire logic              global_freq_select_i,
  input  wire logic              psel_i,
  input  wire logic              penable_i,
  input  wire logic              pwrite_i,
  input  wire logic [7:0]        paddr_i,
  input  wire logic [31:0]       pwdata_i,
  output logic      [31:0]       prdata_o,
  output logic                   pready_o,
  output logic                   pslverr_o,
  output logic      [NPORT-1:0]  port_clk_sel_local_o,
  output logic      [NPORT-1:0]  slot_clock_config_o,
  output logic      [NPORT-1:0]  phy_detect_o,
  output logic      [NPORT-1:0]  serdes_reinit_o,
  output logic      [NPORT-1:0]  link_retrain_o,
  output logic                   global_ref_clock_125_o,
  output logic      [15:0]       core_clk_mhz_o,
  output logic      [15:0]       pcs_clk_mhz_o
);
  typedef struct packed {
    logic [NPORT-1:0] mode;
    logic [NPORT-1:0] sclk;
    logic             merge;
    logic [NPORT-1:0] disabled;
    logic [NPORT-1:0] sel_local;
    logic [1:0]       fsel_sync;
    logic [1:0]       load_sync;
    logic             load_seen;
    logic [2:0]       strap_meta;
    logic [2:0]       strap;
    logic             illegal;
    logic [31:0]      prdata;
    logic             pready;
    logic             pslverr;
  } state_t;
  state_t r, next_r;
  logic [NPORT-1:0] mode_change;
  logic [NPORT-1:0] src_changed;
  logic [NPORT-1:0] detect, reinit, retrain;

  // strap decode used at load time only
  function automatic logic [NPORT-1:0] strap_sclk(input logic [2:0] code);
    logic [NPORT-1:0] v;
    v = '0;
    case (code)
      3'h1: v[0] = 1'b1;
      3'h2: v = {{(NPORT-1){1'b1}}, 1'b0};
      3'h3: v = '1;
      default: v = '0;
    endcase
    return v;
  endfunction

  // even port clock feeds a merged x8 pair; odd pin is ignored
  function automatic logic [NPORT-1:0] eff_src(input logic [NPORT-1:0] m, input logic mg);
    logic [NPORT-1:0] v;
    v = m;
    if (mg) v[1] = m[0];
    return v;
  endfunction

  logic wr, rd;
  assign wr = psel_i && penable_i && pwrite_i && !r.pready;
  assign rd = psel_i && penable_i && !pwrite_i && !r.pready;

  always_comb begin
    next_r = r;
    next_r.fsel_sync = {r.fsel_sync[0], global_freq_select_i};
    next_r.load_sync = {r.load_sync[0], boot_load_i};
    // strap pins cross in too; they settle long before the load level arrives
    next_r.strap_meta = boot_clock_strap_i;
    next_r.strap      = r.strap_meta;
    next_r.pready  = 1'b0;
    next_r.pslverr = 1'b0;
    // strap sampled once, after the load level has settled through the synchroniser
    if (r.load_sync[1] && !r.load_seen) begin
      next_r.load_seen = 1'b1;
      next_r.mode      = {NPORT{refclk_sel_pkg::MODE_GLOBAL}};
      next_r.sclk      = strap_sclk(r.strap);
      next_r.illegal   = r.strap[2];
    end
    if (wr) begin
      next_r.pready = 1'b1;
      case (paddr_i)
        refclk_sel_pkg::MODE_REG_ADDR: next_r.mode = pwdata_i[NPORT-1:0];
        refclk_sel_pkg::LINK_STS_ADDR: next_r.sclk = pwdata_i[NPORT-1:0];
        refclk_sel_pkg::CFG_REG_ADDR: begin
          next_r.merge    = pwdata_i[refclk_sel_pkg::MERGE_BIT];
          next_r.disabled = pwdata_i[refclk_sel_pkg::DISABLE_LSB +: NPORT];
        end
        refclk_sel_pkg::STATUS_REG_ADDR: next_r.pslverr = 1'b1;
        default: next_r.pslverr = 1'b1;
      endcase
    end
    if (rd) begin
      next_r.pready = 1'b1;
      next_r.prdata = refclk_sel_pkg::PSLVERR_NONE;
      case (paddr_i)
        refclk_sel_pkg::MODE_REG_ADDR: next_r.prdata[NPORT-1:0] = r.mode;
        refclk_sel_pkg::LINK_STS_ADDR: next_r.prdata[NPORT-1:0] = r.sclk;
        refclk_sel_pkg::CFG_REG_ADDR: begin
          next_r.prdata[refclk_sel_pkg::MERGE_BIT] = r.merge;
          next_r.prdata[refclk_sel_pkg::DISABLE_LSB +: NPORT] = r.disabled;
        end
        refclk_sel_pkg::STATUS_REG_ADDR: begin
          next_r.prdata[refclk_sel_pkg::FSEL_BIT] = r.fsel_sync[1];
          next_r.prdata[refclk_sel_pkg::DETECT_LSB +: NPORT] = detect;
          next_r.prdata[refclk_sel_pkg::ILLEGAL_BIT] = r.illegal;
        end
        default: next_r.pslverr = 1'b1;
      endcase
    end
    next_r.sel_local = eff_src(r.mode, r.merge);
  end

  // a mode write that flips a port's bit starts its detect sequence
  assign mode_change = next_r.mode ^ r.mode;
  assign src_changed = eff_src(next_r.mode, next_r.merge) ^ eff_src(r.mode, r.merge);

  genvar gi;
  generate
    for (gi = 0; gi < NPORT; gi++) begin : g_port
      port_clk_ctrl u_ctrl (
        .sys_clk_i         (sys_clk_i),
        .rst_n_i           (rst_n_i),
        .ce_i              (ce_i),
        .change_i          (mode_change[gi] | src_changed[gi]),
        .clk_src_changed_i (src_changed[gi]),
        .disabled_i        (r.disabled[gi]),
        .detect_o          (detect[gi]),
        .reinit_o          (reinit[gi]),
        .retrain_o         (retrain[gi])
      );
    end
  endgenerate

  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      r <= '0;
      r.mode <= refclk_sel_pkg::MODE_RESET;
    end else if (ce_i) begin
      r <= next_r;
    end
  end

  always_comb begin
    prdata_o             = r.prdata;
    pready_o             = r.pready;
    pslverr_o            = r.pslverr;
    port_clk_sel_local_o = r.sel_local;
    slot_clock_config_o  = r.sclk;
    phy_detect_o         = detect;
    serdes_reinit_o      = reinit;
    link_retrain_o       = retrain;
    global_ref_clock_125_o           = r.fsel_sync[1];
    core_clk_mhz_o       = 16'(refclk_sel_pkg::CORE_MHZ);
    pcs_clk_mhz_o        = 16'(refclk_sel_pkg::PCS_MHZ);
  end

  a_strap_global: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    (ce_i && r.load_sync[1] && !r.load_seen && !wr) |=> r.mode == '0)
    else $error("strap load left a port in local mode");
  a_strap_sclk: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    (ce_i && r.load_sync[1] && !r.load_seen && !wr && r.strap == 3'h1)
    |=> slot_clock_config_o == 3'h1)
    else $error("strap code one slot clock wrong");
  a_strap_zero: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    (ce_i && r.load_sync[1] && !r.load_seen && !wr && r.strap == 3'h0)
    |=> slot_clock_config_o == 3'h0)
    else $error("strap code zero slot clock wrong");
  a_strap_upper: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    (ce_i && r.load_sync[1] && !r.load_seen && !wr && r.strap == 3'h2)
    |=> slot_clock_config_o == 3'h6)
    else $error("strap code two slot clock wrong");
  a_strap_all: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    (ce_i && r.load_sync[1] && !r.load_seen && !wr && r.strap == 3'h3)
    |=> slot_clock_config_o == 3'h7)
    else $error("strap code three slot clock wrong");
  a_sclk_hold: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    (ce_i && r.load_seen && !(wr && paddr_i == refclk_sel_pkg::LINK_STS_ADDR))
    |=> $stable(slot_clock_config_o))
    else $error("slot clock advert changed without a write");
  a_sel_follow: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    (ce_i && !r.merge) |=> port_clk_sel_local_o == $past(r.mode))
    else $error("clock select does not follow mode");
  a_merge_even: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    (ce_i && r.merge) |=> port_clk_sel_local_o[1] == $past(r.mode[0]))
    else $error("merged port not on even clock");
  a_merge_port0: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    (ce_i && r.merge) |=> port_clk_sel_local_o[0] == $past(r.mode[0]))
    else $error("even port select lost under merge");
  a_mode_indep: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    (ce_i && wr && paddr_i == refclk_sel_pkg::MODE_REG_ADDR)
    |=> r.mode == $past(pwdata_i[2:0]))
    else $error("per-port mode write lost");
  a_mode_hold: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    (ce_i && !(wr && paddr_i == refclk_sel_pkg::MODE_REG_ADDR)
     && !(r.load_sync[1] && !r.load_seen)) |=> $stable(r.mode))
    else $error("mode bits changed without a write");
  a_mode_read: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    (ce_i && rd && paddr_i == refclk_sel_pkg::MODE_REG_ADDR)
    |=> prdata_o[NPORT-1:0] == $past(r.mode))
    else $error("mode read back wrong");
  a_fsel_sync: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    ce_i [*2] |=> global_ref_clock_125_o == $past(global_freq_select_i, 2))
    else $error("frequency select not tracked");
  a_fsel_read: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    (ce_i && rd && paddr_i == refclk_sel_pkg::STATUS_REG_ADDR)
    |=> prdata_o[refclk_sel_pkg::FSEL_BIT] == $past(global_ref_clock_125_o))
    else $error("frequency select status wrong");
  a_sclk_out: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    (ce_i && wr && paddr_i == refclk_sel_pkg::LINK_STS_ADDR)
    |=> slot_clock_config_o == $past(pwdata_i[2:0]))
    else $error("slot clock advert not written");
  a_sclk_read: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    (ce_i && rd && paddr_i == refclk_sel_pkg::LINK_STS_ADDR)
    |=> prdata_o[NPORT-1:0] == $past(r.sclk))
    else $error("slot clock read back wrong");
  a_change_detect: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    (ce_i && mode_change[0] && !detect[0]) |=> phy_detect_o[0])
    else $error("mode change did not reach detect");
  a_src_detect: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    (ce_i && src_changed[1] && !detect[1]) |=> phy_detect_o[1])
    else $error("source change did not reach detect");
  a_detect_read: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    (ce_i && rd && paddr_i == refclk_sel_pkg::STATUS_REG_ADDR)
    |=> prdata_o[refclk_sel_pkg::DETECT_LSB +: NPORT] == $past(detect))
    else $error("detect status wrong");

  c_strap_load: cover property (@(posedge sys_clk_i) r.load_sync[1] && !r.load_seen);
  c_no_retrain: cover property (@(posedge sys_clk_i) serdes_reinit_o[2] && !link_retrain_o[2]);
  c_mode_local: cover property (@(posedge sys_clk_i) port_clk_sel_local_o[2]);
  c_retrain:    cover property (@(posedge sys_clk_i) link_retrain_o[0]);
  c_merge:      cover property (@(posedge sys_clk_i) r.merge && port_clk_sel_local_o[1]);
endmodule
`default_nettype wire

//--- test/board_model.sv
// board model: boot strap vector and global clock frequency select pin
`default_nettype none
module board_model (
  input  wire logic       sys_clk_i,
  input  wire logic [1:0] code_i,
  input  wire logic       go_i,
  input  wire logic       fsel_i,
  output logic      [2:0] strap_o,
  output logic            load_o,
  output logic            fsel_o
);
  timeunit 1ns;
  timeprecision 1ns;
  // clocks on this board carry no spread spectrum, so local mode stays legal
  // reserved codes are never presented: the top strap bit is held low
  always @(posedge sys_clk_i) begin
    strap_o <= {1'b0, code_i};
    load_o  <= go_i;
    fsel_o  <= fsel_i;
  end
endmodule
`default_nettype wire

//--- test/port_refclk_mode_select_tb.sv
// self-checking bench for the port reference clock selector
`default_nettype none
module port_refclk_mode_select_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic        sys_clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic [31:0] rd;
  logic        pready;
  logic        pslverr;
  logic        err;
  logic [1:0]  code = 2'h0;
  logic        go = 1'b0;
  logic        fsel = 1'b0;
  logic        clr = 1'b0;
  logic [2:0]  strap;
  logic [2:0]  sel;
  logic [2:0]  sclk;
  logic [2:0]  det;
  logic [2:0]  reinit;
  logic [2:0]  retrain;
  logic [2:0]  rseen = 3'h0;
  logic [2:0]  tseen = 3'h0;
  logic        load;
  logic        fsel_pin;
  logic        g125;
  logic [15:0] core_mhz;
  logic [15:0] pcs_mhz;
  int          n_errors = 0;
  int          cmp_count = 0;
  int          cyc = 0;

  board_model i_board (.sys_clk_i(sys_clk), .code_i(code), .go_i(go), .fsel_i(fsel),
    .strap_o(strap), .load_o(load), .fsel_o(fsel_pin));

  port_refclk_mode_select i_dut (.sys_clk_i(sys_clk), .rst_n_i(rst_n), .ce_i(1'b1),
    .boot_clock_strap_i(strap), .boot_load_i(load), .global_freq_select_i(fsel_pin),
    .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr),
    .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
    .port_clk_sel_local_o(sel), .slot_clock_config_o(sclk), .phy_detect_o(det),
    .serdes_reinit_o(reinit), .link_retrain_o(retrain), .global_ref_clock_125_o(g125),
    .core_clk_mhz_o(core_mhz), .pcs_clk_mhz_o(pcs_mhz));

  initial begin
    forever #25 sys_clk = ~sys_clk;
  end

  // pulses last one cycle, so they are gathered here rather than polled
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (clr) begin
      rseen <= 3'h0;
      tseen <= 3'h0;
    end else begin
      rseen <= rseen | reinit;
      tseen <= tseen | retrain;
    end
    if (cyc == 5000) begin
      n_errors++;
      final_report();
    end
  end

  task automatic final_report();
    $display("errors %0d comparisons %0d", n_errors, cmp_count);
    if (n_errors == 0 && cmp_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    @(posedge sys_clk);
    // no cycle count is assumed: only the bench timeout ends this wait
    while (pready !== 1'b1) begin
      @(posedge sys_clk);
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic boot(input logic [1:0] c);
    rst_n <= 1'b0;
    go <= 1'b0;
    code <= c;
    repeat (12) @(posedge sys_clk);
    rst_n <= 1'b1;
    go <= 1'b1;
    repeat (8) @(posedge sys_clk);
  endtask

  // write that may change a clock source, then wait out the detect hold
  task automatic chg(input logic [7:0] a, input logic [31:0] d, input logic [2:0] exp_det);
    int n;
    n = 0;
    clr <= 1'b1;
    apb(1'b1, a, d);
    clr <= 1'b0;
    repeat (3) @(posedge sys_clk);
    check("detect", 32'(det), 32'(exp_det));
    while (det !== 3'h0) begin
      @(posedge sys_clk);
      n++;
    end
    // detect stands DETECT_CYC + 1 cycles; three of them passed before the loop
    check("hold", 32'(n), 32'(refclk_sel_pkg::DETECT_CYC - 2));
    repeat (2) @(posedge sys_clk);
  endtask

  initial begin
    for (int c = 0; c < 4; c++) begin
      boot(c[1:0]);
      check("slot", 32'(sclk), 32'({c[1], c[1], c[0]}));
      check("sel", 32'(sel), 32'h0);
      apb(1'b0, refclk_sel_pkg::MODE_REG_ADDR, 32'h0);
      check("mode", rd, 32'h0);
      apb(1'b0, refclk_sel_pkg::LINK_STS_ADDR, 32'h0);
      check("sts", rd, 32'({c[1], c[1], c[0]}));
    end
    check("core", 32'(core_mhz), 32'h0000_00FA);
    check("pcs", 32'(pcs_mhz), 32'h0000_00FA);
    chg(refclk_sel_pkg::MODE_REG_ADDR, 32'h0000_0005, 3'h5);
    check("sel5", 32'(sel), 32'h5);
    check("reinit", 32'(rseen), 32'h5);
    check("retrain", 32'(tseen), 32'h5);
    apb(1'b1, refclk_sel_pkg::CFG_REG_ADDR, 32'h0000_0040);
    check("cfg_err", 32'(err), 32'h0);
    chg(refclk_sel_pkg::MODE_REG_ADDR, 32'h0000_0001, 3'h4);
    check("reinit2", 32'(rseen), 32'h4);
    check("retrain2", 32'(tseen), 32'h0);
    chg(refclk_sel_pkg::CFG_REG_ADDR, 32'h0000_0001, 3'h2);
    check("merge", 32'(sel), 32'h3);
    fsel <= 1'b1;
    repeat (8) @(posedge sys_clk);
    check("g125", 32'(g125), 32'h1);
    apb(1'b0, refclk_sel_pkg::STATUS_REG_ADDR, 32'h0);
    check("fsel", 32'(rd[refclk_sel_pkg::FSEL_BIT]), 32'h1);
    apb(1'b1, refclk_sel_pkg::STATUS_REG_ADDR, 32'hFFFF_FFFF);
    check("ro_err", 32'(err), 32'h1);
    apb(1'b1, 8'h10, 32'h0000_0007);
    check("unmap", 32'(err), 32'h1);
    apb(1'b1, refclk_sel_pkg::LINK_STS_ADDR, 32'h0000_0002);
    repeat (2) @(posedge sys_clk);
    check("adv", 32'(sclk), 32'h2);
    check("sel_kept", 32'(sel), 32'h3);
    final_report();
  end
endmodule
`default_nettype wire
